// [rtl/rtc_core.sv]
// Purpose: Calendar clock with alarms, stopwatch, tick events and wakeup, AXI4-Lite slave
// Assumes: xtal_32k is a free running 32.768 kHz level from a pin, slower than aclk/4
// Notes: Status bits are write-one-to-clear; a new event beats a clear in the same cycle
`default_nettype none
`include "rtc_defs.svh"
module rtc_core #(
  parameter int PRESCALE = `RTC_PRESCALE,
  parameter int SW_W     = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        xtal_32k,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  output logic             wakeup
);

  localparam int PW = $clog2(PRESCALE);

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  // Crystal synchroniser and edge history
  logic xs1_reg;
  logic xs2_reg;
  logic xs3_reg;

  // Timekeeping state
  logic [PW-1:0]      pre_reg, pre_next;
  rtc_pkg::time_s     now_reg, now_next;
  rtc_pkg::time_s     alm_reg, alm_next;
  rtc_pkg::ctrl_t     ctrl_reg, ctrl_next;
  logic [SW_W-1:0]    sw_reg, sw_next;
  rtc_pkg::event_t    stat_reg, stat_next;
  rtc_pkg::event_t    mask_reg, mask_next;
  rtc_pkg::event_t    wken_reg, wken_next;
  logic               irq_reg, irq_next;
  logic               wake_reg, wake_next;

  // Bus state
  logic [7:0]         wa_reg, wa_next;
  logic               aw_full_reg, aw_full_next;
  logic [31:0]        wd_reg, wd_next;
  logic [3:0]         ws_reg, ws_next;
  logic               w_full_reg, w_full_next;
  logic               awready_reg, awready_next;
  logic               wready_reg, wready_next;
  logic               bvalid_reg, bvalid_next;
  logic [1:0]         bresp_reg, bresp_next;
  logic               arready_reg, arready_next;
  logic               rvalid_reg, rvalid_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic [1:0]         rresp_reg, rresp_next;

  // Combinational helpers
  logic               xtal_rise;
  logic               tick;
  logic               c_sec, c_min, c_hour;
  rtc_pkg::time_s     adv;
  rtc_pkg::event_t    ev;
  rtc_pkg::event_t    clr;
  logic               do_wr;
  logic [31:0]        wm;

  // Prescaler, counters, alarms, stopwatch and events
  always_comb begin
    xtal_rise = xs2_reg & ~xs3_reg;
    tick      = xtal_rise && (pre_reg == PW'(PRESCALE - 1));
    pre_next  = pre_reg;
    if (xtal_rise) begin
      pre_next = tick ? '0 : pre_reg + PW'(1);
    end
    adv    = now_reg;
    c_sec  = tick && (now_reg.sec == `RTC_SEC_LAST);
    c_min  = c_sec && (now_reg.min == `RTC_MIN_LAST);
    c_hour = c_min && (now_reg.hour == `RTC_HOUR_LAST);
    if (tick) begin
      adv.sec = c_sec ? 6'h00 : now_reg.sec + 6'h01;
    end
    if (c_sec) begin
      adv.min = c_min ? 6'h00 : now_reg.min + 6'h01;
    end
    if (c_min) begin
      adv.hour = c_hour ? 5'h00 : now_reg.hour + 5'h01;
    end
    if (c_hour) begin
      adv.day = now_reg.day + 15'h0001; // Wraps after 32767
    end
    ev = '0;
    ev[`RTC_EV_SEC]  = tick;
    ev[`RTC_EV_MIN]  = c_sec;
    ev[`RTC_EV_HOUR] = c_min;
    ev[`RTC_EV_DAY]  = c_hour;
    ev[`RTC_EV_ALM]  = tick && ctrl_reg[`RTC_CTRL_ALM] &&
                       ({adv.hour, adv.min, adv.sec} == {alm_reg.hour, alm_reg.min, alm_reg.sec});
    ev[`RTC_EV_DALM] = tick && ctrl_reg[`RTC_CTRL_DALM] && (adv == alm_reg);
    sw_next = sw_reg;
    if (tick && ctrl_reg[`RTC_CTRL_SW] && (sw_reg != '0)) begin
      sw_next = sw_reg - SW_W'(1);
    end
    ev[`RTC_EV_SW] = tick && ctrl_reg[`RTC_CTRL_SW] && (sw_reg == SW_W'(1));

    now_next  = adv;
    alm_next  = alm_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    wken_next = wken_reg;
    clr       = '0;
    do_wr     = aw_full_reg && w_full_reg && !bvalid_reg;
    wm        = `RTC_RST_WORD;
    if (do_wr) begin
      unique case (wa_reg)
        `RTC_OFF_TIME: begin
          now_next = merge(now_reg, wd_reg, ws_reg);
          pre_next = '0; // Restart the second on a time load
        end
        `RTC_OFF_ALARM:  alm_next  = merge(alm_reg, wd_reg, ws_reg);
        `RTC_OFF_CTRL: begin
          wm        = merge(32'(ctrl_reg), wd_reg, ws_reg);
          ctrl_next = wm[2:0];
        end
        `RTC_OFF_SWATCH: begin
          wm      = merge(32'(sw_reg), wd_reg, ws_reg);
          sw_next = wm[SW_W-1:0];
        end
        `RTC_OFF_STAT: begin
          wm  = merge(`RTC_RST_WORD, wd_reg, ws_reg);
          clr = wm[6:0];
        end
        `RTC_OFF_MASK: begin
          wm        = merge(32'(mask_reg), wd_reg, ws_reg);
          mask_next = wm[6:0];
        end
        `RTC_OFF_WAKE: begin
          wm        = merge(32'(wken_reg), wd_reg, ws_reg);
          wken_next = wm[6:0];
        end
        default: wm = `RTC_RST_WORD;
      endcase
    end
    stat_next = (stat_reg & ~clr) | ev;
    irq_next  = |(stat_reg & mask_reg);
    wake_next = |(stat_reg & wken_reg);
  end

  // Timekeeping registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xs1_reg  <= 1'b0;
      xs2_reg  <= 1'b0;
      xs3_reg  <= 1'b0;
      pre_reg  <= '0;
      now_reg  <= '0;
      alm_reg  <= '0;
      ctrl_reg <= '0;
      sw_reg   <= '0;
      stat_reg <= '0;
      mask_reg <= '0;
      wken_reg <= '0;
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      xs1_reg  <= xtal_32k;
      xs2_reg  <= xs1_reg;
      xs3_reg  <= xs2_reg;
      pre_reg  <= pre_next;
      now_reg  <= now_next;
      alm_reg  <= alm_next;
      ctrl_reg <= ctrl_next;
      sw_reg   <= sw_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      wken_reg <= wken_next;
      irq_reg  <= irq_next;
      wake_reg <= wake_next;
    end
  end

  // AXI4-Lite write and read channels
  always_comb begin
    wa_next      = wa_reg;
    wd_next      = wd_reg;
    ws_next      = ws_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (awvalid && awready_reg) begin
      wa_next      = awaddr;
      aw_full_next = 1'b1;
    end
    if (wvalid && wready_reg) begin
      wd_next     = wdata;
      ws_next     = wstrb;
      w_full_next = 1'b1;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wa_reg <= `RTC_OFF_WAKE && wa_reg[1:0] == 2'h0) ? `RTC_RESP_OKAY : `RTC_RESP_SLV;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `RTC_RESP_OKAY;
      unique case (araddr)
        `RTC_OFF_TIME:   rdata_next = now_reg;
        `RTC_OFF_ALARM:  rdata_next = alm_reg;
        `RTC_OFF_CTRL:   rdata_next = 32'(ctrl_reg);
        `RTC_OFF_SWATCH: rdata_next = 32'(sw_reg);
        `RTC_OFF_STAT:   rdata_next = 32'(stat_reg);
        `RTC_OFF_MASK:   rdata_next = 32'(mask_reg);
        `RTC_OFF_WAKE:   rdata_next = 32'(wken_reg);
        default: begin
          rdata_next = `RTC_RST_WORD;
          rresp_next = `RTC_RESP_SLV;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_reg      <= 8'h00;
      wd_reg      <= `RTC_RST_WORD;
      ws_reg      <= 4'h0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RTC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `RTC_RST_WORD;
      rresp_reg   <= `RTC_RESP_OKAY;
    end else begin
      wa_reg      <= wa_next;
      wd_reg      <= wd_next;
      ws_reg      <= ws_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Outputs straight from flops
  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign irq     = irq_reg;
  assign wakeup  = wake_reg;

endmodule // rtc_core
`default_nettype wire

// [include/rtc_defs.svh]
// Purpose: Offsets, field positions, reset values and counts of the calendar clock
// Assumes: Byte addresses of 32-bit AXI4-Lite words
// Notes: Included by bare name
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_OFF_TIME   8'h00
`define RTC_OFF_ALARM  8'h04
`define RTC_OFF_CTRL   8'h08
`define RTC_OFF_SWATCH 8'h0c
`define RTC_OFF_STAT   8'h10
`define RTC_OFF_MASK   8'h14
`define RTC_OFF_WAKE   8'h18
`define RTC_PRESCALE   32768
`define RTC_SEC_LAST   6'h3b
`define RTC_MIN_LAST   6'h3b
`define RTC_HOUR_LAST  5'h17
`define RTC_EV_SEC     0
`define RTC_EV_MIN     1
`define RTC_EV_HOUR    2
`define RTC_EV_DAY     3
`define RTC_EV_ALM     4
`define RTC_EV_DALM    5
`define RTC_EV_SW      6
`define RTC_CTRL_ALM   0
`define RTC_CTRL_DALM  1
`define RTC_CTRL_SW    2
`define RTC_RST_WORD   32'h0000_0000
`define RTC_RESP_OKAY  2'h0
`define RTC_RESP_SLV   2'h2
`endif

// [include/rtc_pkg.sv]
// Purpose: Types shared by the calendar clock
// Assumes: Nothing
// Notes: Layout of time_s is the layout of the time and alarm words
`default_nettype none
package rtc_pkg;
  typedef struct packed {
    logic [14:0] day;
    logic [4:0]  hour;
    logic [5:0]  min;
    logic [5:0]  sec;
  } time_s;
  typedef logic [6:0] event_t;
  typedef logic [2:0] ctrl_t;
endpackage
`default_nettype wire

// [verif/rtc_core_checker.sv]
// Purpose: Bus handshake and event output assertions for rtc_core
// Assumes: One aclk domain, synchronous active low reset
// Notes: Bound to every rtc_core instance below
`default_nettype none
module rtc_core_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        xtal_32k,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        irq,
  input wire logic        wakeup
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       x_reg;
  logic       x_next;
  logic [3:0] since_reg;
  logic [3:0] since_next;
  // Cycles since the crystal pin rose, saturating
  always_comb begin
    x_next     = xtal_32k;
    since_next = since_reg + {3'h0, since_reg != 4'hf};
    if (!aresetn) since_next = 4'hf;
    else if (xtal_32k && !x_reg) since_next = 4'h0;
  end
  always_ff @(posedge aclk) begin
    x_reg     <= x_next;
    since_reg <= since_next;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_turn: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped or changed");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped or changed");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  a_unmapped_err: assert property (arvalid && arready && araddr > 8'h18 |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_irq_clear: assert property ($fell(irq) |-> $past(bvalid))
    else $error("interrupt dropped without a write");
  a_irq_cause: assert property ($rose(irq) |-> since_reg < 4'hc || $past(bvalid))
    else $error("interrupt rose without tick or write");
  a_wake_cause: assert property ($rose(wakeup) |-> since_reg < 4'hc || $past(bvalid))
    else $error("wakeup rose without tick or write");
endmodule // rtc_core_checker
bind rtc_core rtc_core_checker u_rtc_core_checker (.aclk, .aresetn, .xtal_32k, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .wakeup);
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for rtc_core
// Assumes: Second shortened to 4 crystal rises
// Notes: Crystal stand-in rises every 8 cycles
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, xtal_32k = 0;
  logic [2:0]  xc = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_v;
  logic [3:0]  wstrb = 0, lanes = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, wakeup;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [6:0]  ab;
  int          n_mismatch = 0, n_compared = 0, k, cyc;
  rtc_pkg::time_s t, a;
  rtc_core #(.PRESCALE(4)) u_rtc_core (.aclk, .aresetn, .xtal_32k, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq, .wakeup);
  always #5 aclk = ~aclk;
  // Crystal stand-in
  always @(posedge aclk) begin
    xc       <= xc + 3'h1;
    xtal_32k <= xc[2];
  end
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, s, e);
    end
  endtask
  task automatic bail();
    n_mismatch++;
    test_done();
  endtask
  // Write one word, address and data offered together
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {ad, d, lanes};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (n > 100) bail();
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) {wr_r, bready} <= {bresp, 1'b0};
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] ad);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= ad;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (n > 100) bail();
      if (arready) arvalid <= 1'b0;
      if (rvalid) {rd_v, rd_r, rready} <= {rdata, rresp, 1'b0};
    end while (arvalid || rready);
  endtask
  task automatic wirq();
    for (cyc = 0; irq !== 1'b1; cyc++) begin
      @(posedge aclk);
      if (cyc > 300) bail();
    end
  endtask
  // Expected time one tick later
  function automatic rtc_pkg::time_s nx(input rtc_pkg::time_s p);
    rtc_pkg::time_s r;
    r = p;
    r.sec = p.sec + 6'h1;
    if (p.sec == 6'h3b) begin
      r.sec = 6'h0;
      r.min = p.min + 6'h1;
      if (p.min == 6'h3b) begin
        r.min = 6'h0;
        r.hour = p.hour == 5'h17 ? 5'h0 : p.hour + 5'h1;
        if (p.hour == 5'h17) r.day = p.day + 15'h1;
      end
    end
    return r;
  endfunction
  // Expected tick events of that tick
  function automatic logic [31:0] ev(input rtc_pkg::time_s p);
    ev = {28'h0, p.hour == 5'h17 && p.min == 6'h3b && p.sec == 6'h3b, p.min == 6'h3b && p.sec == 6'h3b,
          p.sec == 6'h3b, 1'b1};
  endfunction
  function automatic rtc_pkg::time_s rnd();
    rnd = {15'($urandom), 5'($urandom % 24), 6'($urandom % 60), 6'($urandom % 60)};
  endfunction
  initial begin
    void'($urandom(85));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped word
    for (k = 0; k < 8; k++) begin
      rd(8'(k * 4));
      chk(rd_v, 32'h0);
      chk(rd_r, k == 7 ? 2'h2 : 2'h0);
    end
    $display("test reset done");
    // Unmapped write refused, full and single-lane writes read back
    wr(8'h1c, 32'hffff_ffff);
    chk(wr_r, 2'h2);
    wr(8'h04, 32'h1234_5678);
    chk(wr_r, 2'h0);
    lanes = 4'h2;
    wr(8'h04, 32'hffff_ffff);
    lanes = 4'hf;
    rd(8'h04);
    chk(rd_v, 32'h1234_ff78);
    $display("test bus done");
    wr(8'h14, 32'hf);
    for (k = 0; k < 6; k++) begin
      t = rnd();
      if (k < 3) {t.min, t.sec} = {6'h3b, 6'h3b};
      if (k == 0) {t.day, t.hour} = {15'h7fff, 5'h17};
      wr(8'h00, t);
      wr(8'h10, 32'h7f);
      chk(irq, 1'b0);
      wirq();
      rd(8'h00);
      chk(rd_v, nx(t));
      rd(8'h10);
      chk(rd_v, ev(t));
    end
    $display("test counters done");
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h30);
    for (k = 0; k < 3; k++) begin
      t = rnd();
      a = nx(t);
      if (k < 2) a.day = a.day + 15'h5;
      ab = k == 0 ? 7'h10 : k == 1 ? 7'h0 : 7'h20;
      wr(8'h08, k == 0 ? 32'h1 : 32'h2);
      wr(8'h04, a);
      wr(8'h00, t);
      wr(8'h10, 32'h7f);
      wirq();
      chk(wakeup, ab != 0);
      rd(8'h10);
      chk(rd_v, ev(t) | ab);
    end
    $display("test alarms done");
    wr(8'h08, 32'h4);
    wr(8'h14, 32'h40);
    wr(8'h10, 32'h7f);
    wr(8'h0c, 32'h2);
    wirq();
    chk(cyc > 32 && cyc < 65, 1'b1);
    chk(wakeup, 1'b0);
    rd(8'h0c);
    chk(rd_v, 32'h0);
    rd(8'h10);
    chk(rd_v & 32'h40, 32'h40);
    $display("test stopwatch done");
    test_done();
  end
endmodule // tb
`default_nettype wire
